// ### rtl/itmr_capture.sv
`timescale 1ns/1ps
module itmr_capture #(
   parameter int CNT_W = itmr_pkg::CNT_W,
   parameter int HALF_W = itmr_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic captureEn,
   input wire logic [CNT_W-1:0] liveCount,
   output logic [HALF_W-1:0] capturedLow,
   output logic [HALF_W-1:0] capturedHigh
);

   logic [CNT_W-1:0] held_r;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         held_r <= itmr_pkg::CAPTURE_RST;
      end else if (captureEn) begin
         held_r <= liveCount;
      end
   end

   assign capturedLow = held_r[HALF_W-1:0];
   assign capturedHigh = held_r[CNT_W-1:HALF_W];

endmodule

// ### rtl/itmr_counter.sv
`timescale 1ns/1ps
module itmr_counter #(
   parameter int CNT_W = itmr_pkg::CNT_W,
   parameter logic [CNT_W-1:0] RESET_COUNT = itmr_pkg::DEFAULT_COUNT
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic startCmd,
   input wire logic stopCmd,
   input wire logic loadEn,
   input wire logic [CNT_W-1:0] loadValue,
   input wire logic [CNT_W-1:0] period,
   input wire logic contMode,
   output logic [CNT_W-1:0] count,
   output logic running,
   output logic zeroHit
);

   typedef enum logic {IDLE, COUNTING} itmr_run_t;

   itmr_run_t state_r;
   itmr_run_t state_nxt;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_r <= IDLE;
         count_r <= RESET_COUNT;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
      end
   end

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      zeroHit = 1'b0;
      case (state_r)
         IDLE: begin
            if (startCmd && !stopCmd) begin
               state_nxt = COUNTING;
            end
         end
         COUNTING: begin
            if (stopCmd) begin
               state_nxt = IDLE;
            end else if (count_r == '0) begin
               zeroHit = 1'b1;
               count_nxt = period;
               if (!contMode) begin
                  state_nxt = IDLE;
               end
            end else begin
               count_nxt = count_r - 1'b1;
            end
         end
         default: begin
            state_nxt = IDLE;
         end
      endcase
      // New period takes effect at once
      if (loadEn) begin
         count_nxt = loadValue;
      end
   end

   assign count = count_r;
   assign running = (state_r == COUNTING);

endmodule

// ### rtl/itmr_pkg.sv
package itmr_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam int CNT_W = 32;

   // ***************************************************************
   // Register byte addresses
   // ***************************************************************
   localparam logic [ADDR_W-1:0] TIMER_STATE_ADDR = 32'h1000_2000;
   localparam logic [ADDR_W-1:0] TIMER_SETTINGS_ADDR = 32'h1000_2004;
   localparam logic [ADDR_W-1:0] PERIOD_LOW_HALF_ADDR = 32'h1000_2008;
   localparam logic [ADDR_W-1:0] PERIOD_HIGH_HALF_ADDR = 32'h1000_200C;
   localparam logic [ADDR_W-1:0] CAPTURED_COUNT_LOW_ADDR = 32'h1000_2010;
   localparam logic [ADDR_W-1:0] CAPTURED_COUNT_HIGH_ADDR = 32'h1000_2014;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int TIMEOUT_FLAG_BIT = 0;
   localparam int RUNNING_BIT = 1;
   localparam int TIMEOUT_IRQ_ENABLE_BIT = 0;
   localparam int CONTINUOUS_MODE_BIT = 1;
   localparam int START_BIT = 2;
   localparam int STOP_BIT = 3;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic TIMEOUT_FLAG_RST = 1'b0;
   localparam logic IRQ_PENDING_RST = 1'b0;
   localparam logic TIMEOUT_IRQ_ENABLE_RST = 1'b0;
   localparam logic CONTINUOUS_MODE_RST = 1'b0;
   localparam logic [DATA_W-1:0] READ_IDLE_VALUE = 16'h0000;
   localparam logic [CNT_W-1:0] CAPTURE_RST = 32'h0000_0000;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int DEFAULT_PERIOD_US = 125000;
   localparam int COUNT_CLK_MHZ = 50;
   localparam logic [CNT_W-1:0] DEFAULT_COUNT = CNT_W'(DEFAULT_PERIOD_US * COUNT_CLK_MHZ);

endpackage

// ### rtl/itmr_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module itmr_top #(
   parameter logic [itmr_pkg::CNT_W-1:0] RESET_COUNT = itmr_pkg::DEFAULT_COUNT
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [itmr_pkg::ADDR_W-1:0] busAddr,
   input wire logic [itmr_pkg::DATA_W-1:0] busWrData,
   input wire logic busWrStb,
   input wire logic busRdStb,
   output logic [itmr_pkg::DATA_W-1:0] busRdData,
   output logic timerIrq
);

   localparam int DW = itmr_pkg::DATA_W;
   localparam int CW = itmr_pkg::CNT_W;

   // ***************************************************************
   // Address decode
   // ***************************************************************
   wire logic hitState;
   wire logic hitSettings;
   wire logic hitPeriodLow;
   wire logic hitPeriodHigh;
   wire logic hitCaptLow;
   wire logic hitCaptHigh;
   wire logic wrState;
   wire logic wrSettings;
   wire logic wrPeriodLow;
   wire logic wrPeriodHigh;
   wire logic wrCaptLow;

   assign hitState = (busAddr == itmr_pkg::TIMER_STATE_ADDR);
   assign hitSettings = (busAddr == itmr_pkg::TIMER_SETTINGS_ADDR);
   assign hitPeriodLow = (busAddr == itmr_pkg::PERIOD_LOW_HALF_ADDR);
   assign hitPeriodHigh = (busAddr == itmr_pkg::PERIOD_HIGH_HALF_ADDR);
   assign hitCaptLow = (busAddr == itmr_pkg::CAPTURED_COUNT_LOW_ADDR);
   assign hitCaptHigh = (busAddr == itmr_pkg::CAPTURED_COUNT_HIGH_ADDR);

   assign wrState = busWrStb & hitState;
   assign wrSettings = busWrStb & hitSettings;
   assign wrPeriodLow = busWrStb & hitPeriodLow;
   assign wrPeriodHigh = busWrStb & hitPeriodHigh;
   assign wrCaptLow = busWrStb & hitCaptLow;

   // ***************************************************************
   // Control settings
   // ***************************************************************
   logic irqEnable_r;
   logic contMode_r;
   logic [CW-1:0] period_r;
   wire logic [CW-1:0] period_nxt;
   wire logic startCmd;
   wire logic stopCmd;
   wire logic periodLoad;

   assign startCmd = wrSettings & busWrData[itmr_pkg::START_BIT];
   assign stopCmd = wrSettings & busWrData[itmr_pkg::STOP_BIT];

   assign period_nxt = wrPeriodLow ? {period_r[CW-1:DW], busWrData} :
                       wrPeriodHigh ? {busWrData, period_r[DW-1:0]} :
                       period_r;
   assign periodLoad = wrPeriodLow | wrPeriodHigh;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irqEnable_r <= itmr_pkg::TIMEOUT_IRQ_ENABLE_RST;
         contMode_r <= itmr_pkg::CONTINUOUS_MODE_RST;
      end else if (wrSettings) begin
         irqEnable_r <= busWrData[itmr_pkg::TIMEOUT_IRQ_ENABLE_BIT];
         contMode_r <= busWrData[itmr_pkg::CONTINUOUS_MODE_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         period_r <= RESET_COUNT;
      end else begin
         period_r <= period_nxt;
      end
   end

   // ***************************************************************
   // Counter and snapshot
   // ***************************************************************
   logic [CW-1:0] liveCount;
   logic running;
   logic zeroHit;
   logic [DW-1:0] capturedLow;
   logic [DW-1:0] capturedHigh;

   itmr_counter #(
      .CNT_W(CW),
      .RESET_COUNT(RESET_COUNT)
   ) uCounter (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .startCmd(startCmd),
      .stopCmd(stopCmd),
      .loadEn(periodLoad),
      .loadValue(period_nxt),
      .period(period_r),
      .contMode(contMode_r),
      .count(liveCount),
      .running(running),
      .zeroHit(zeroHit)
   );

   itmr_capture #(
      .CNT_W(CW),
      .HALF_W(DW)
   ) uCapture (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .captureEn(wrCaptLow),
      .liveCount(liveCount),
      .capturedLow(capturedLow),
      .capturedHigh(capturedHigh)
   );

   // ***************************************************************
   // Timeout flag and interrupt request
   // ***************************************************************
   logic timeoutFlag_r;
   logic irqPending_r;
   wire logic timeoutClear;
   wire logic timeoutFlag_nxt;
   wire logic irqPending_nxt;

   assign timeoutClear = wrState & ~busWrData[itmr_pkg::TIMEOUT_FLAG_BIT];
   assign timeoutFlag_nxt = zeroHit | (timeoutFlag_r & ~timeoutClear);
   assign irqPending_nxt = (zeroHit & irqEnable_r) | (irqPending_r & ~wrState);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         timeoutFlag_r <= itmr_pkg::TIMEOUT_FLAG_RST;
         irqPending_r <= itmr_pkg::IRQ_PENDING_RST;
      end else begin
         timeoutFlag_r <= timeoutFlag_nxt;
         irqPending_r <= irqPending_nxt;
      end
   end

   assign timerIrq = irqPending_r;

   // ***************************************************************
   // Read path
   // ***************************************************************
   logic [DW-1:0] rdData_r;
   wire logic [DW-1:0] stateValue;
   wire logic [DW-1:0] settingsValue;
   wire logic [DW-1:0] readValue;
   wire logic [DW-1:0] rdData_nxt;

   assign stateValue = {{(DW-2){1'b0}}, running, timeoutFlag_r};
   // Start and stop are commands and read back as zero
   assign settingsValue = {{(DW-2){1'b0}}, contMode_r, irqEnable_r};

   assign readValue = hitState ? stateValue :
                      hitSettings ? settingsValue :
                      hitPeriodLow ? period_r[DW-1:0] :
                      hitPeriodHigh ? period_r[CW-1:DW] :
                      hitCaptLow ? capturedLow :
                      hitCaptHigh ? capturedHigh :
                      itmr_pkg::READ_IDLE_VALUE;
   assign rdData_nxt = busRdStb ? readValue : itmr_pkg::READ_IDLE_VALUE;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdData_r <= itmr_pkg::READ_IDLE_VALUE;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   assign busRdData = rdData_r;

endmodule

// ### sim/itmr_asserts.sv
`timescale 1ns/1ps
module itmr_asserts #(
   parameter logic [31:0] RESET_COUNT = itmr_pkg::DEFAULT_COUNT
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [31:0] busAddr,
   input wire logic [15:0] busWrData,
   input wire logic busWrStb,
   input wire logic busRdStb,
   input wire logic [15:0] busRdData,
   input wire logic timerIrq
);
   // *****
   // Shadow of the writable settings
   // *****
   logic ienR;
   logic contR;
   logic [15:0] perLowR;
   logic [15:0] perHighR;
   wire selState = busAddr == itmr_pkg::TIMER_STATE_ADDR;
   wire selSet = busAddr == itmr_pkg::TIMER_SETTINGS_ADDR;
   wire selLow = busAddr == itmr_pkg::PERIOD_LOW_HALF_ADDR;
   wire selHigh = busAddr == itmr_pkg::PERIOD_HIGH_HALF_ADDR;
   wire selCapL = busAddr == itmr_pkg::CAPTURED_COUNT_LOW_ADDR;
   wire selCapH = busAddr == itmr_pkg::CAPTURED_COUNT_HIGH_ADDR;
   wire mapped = selState | selSet | selLow | selHigh | selCapL | selCapH;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ienR <= itmr_pkg::TIMEOUT_IRQ_ENABLE_RST;
         contR <= itmr_pkg::CONTINUOUS_MODE_RST;
         perLowR <= RESET_COUNT[15:0];
         perHighR <= RESET_COUNT[31:16];
      end else if (busWrStb) begin
         if (selSet) begin
            ienR <= busWrData[0];
            contR <= busWrData[1];
         end
         if (selLow) begin
            perLowR <= busWrData;
         end
         if (selHigh) begin
            perHighR <= busWrData;
         end
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // *****
   // Checks
   // *****
   a_rd_idle_zero: assert property (!busRdStb |=> busRdData == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_rd_unmapped: assert property (busRdStb && !mapped |=> busRdData == 16'h0000)
      else $error("unmapped read not zero");
   a_rd_settings: assert property (busRdStb && selSet |=>
      busRdData == {14'h0000, $past(contR), $past(ienR)})
      else $error("settings read mismatch");
   a_per_low_rd: assert property (busRdStb && selLow |=> busRdData == $past(perLowR))
      else $error("period low half read mismatch");
   a_per_high_rd: assert property (busRdStb && selHigh |=> busRdData == $past(perHighR))
      else $error("period high half read mismatch");
   a_status_unused: assert property (busRdStb && selState |=>
      busRdData[15:2] == 14'h0000)
      else $error("status unused bits not zero");
   a_irq_needs_en: assert property ($rose(timerIrq) |-> $past(ienR))
      else $error("interrupt raised while disabled");
   a_irq_holds: assert property (timerIrq && !(busWrStb && selState) |=> timerIrq)
      else $error("interrupt dropped without status write");
endmodule

// ### sim/itmr_host_model.sv
`timescale 1ns/1ps
module itmr_host_model (
   input wire logic sys_clk,
   output logic [31:0] busAddr,
   output logic [15:0] busWrData,
   output logic busWrStb,
   output logic busRdStb
);
   logic [15:0] expQ[$];
   initial begin
      busAddr <= 32'h0000_0000;
      busWrData <= 16'h0000;
      busWrStb <= 1'b0;
      busRdStb <= 1'b0;
   end
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      busAddr <= a;
      busWrData <= d;
      busWrStb <= 1'b1;
      @(posedge sys_clk);
      busWrStb <= 1'b0;
   endtask
   // Expected read value is queued when the read is issued
   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      busAddr <= a;
      busRdStb <= 1'b1;
      expQ.push_back(e);
      @(posedge sys_clk);
      busRdStb <= 1'b0;
   endtask
endmodule

// ### sim/tb_interval_timer_with_irq.sv
`timescale 1ns/1ps
module tb_interval_timer_with_irq;
   localparam logic [31:0] P = 32'h0000_0014;
   localparam logic [31:0] ST = itmr_pkg::TIMER_STATE_ADDR;
   localparam logic [31:0] SE = itmr_pkg::TIMER_SETTINGS_ADDR;
   localparam logic [31:0] PL = itmr_pkg::PERIOD_LOW_HALF_ADDR;
   localparam logic [31:0] PH = itmr_pkg::PERIOD_HIGH_HALF_ADDR;
   localparam logic [31:0] CL = itmr_pkg::CAPTURED_COUNT_LOW_ADDR;
   localparam logic [31:0] CH = itmr_pkg::CAPTURED_COUNT_HIGH_ADDR;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] busAddr;
   logic [15:0] busWrData;
   logic [15:0] busRdData;
   logic busWrStb;
   logic busRdStb;
   logic timerIrq;
   logic rdLate = 1'b0;
   logic [15:0] rv;
   int err_total = 0;
   int n_compared = 0;
   always #20 sys_clk = ~sys_clk;
   itmr_top #(.RESET_COUNT(P)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .busAddr(busAddr),
      .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb),
      .busRdData(busRdData), .timerIrq(timerIrq));
   itmr_host_model host_u (.sys_clk(sys_clk), .busAddr(busAddr), .busWrData(busWrData),
      .busWrStb(busWrStb), .busRdStb(busRdStb));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // *****
   // Read answer monitor
   // *****
   always @(posedge sys_clk) rdLate <= busRdStb;
   always @(negedge sys_clk) begin
      if (rdLate) begin
         if (host_u.expQ.size() == 0) begin
            chk("read queue", 16'h0000, 16'h0001);
         end else begin
            chk("busRdData", host_u.expQ.pop_front(), busRdData);
         end
      end
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      results();
   end
   // *****
   // Scenarios
   // *****
   initial begin
      void'($urandom(21434));
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         host_u.rd(ST + 32'(4 * i), (i == 2) ? P[15:0] : 16'h0000);
      end
      host_u.wr(SE, 16'hFFF3);
      host_u.rd(SE, 16'h0003);
      rv = 16'($urandom());
      host_u.wr(PH, rv);
      host_u.rd(PH, rv);
      host_u.wr(CH, rv);
      host_u.rd(CH, 16'h0000);
      host_u.wr(PH, 16'h0000);
      host_u.wr(PL, 16'h0005);
      host_u.wr(SE, 16'h0005);
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("timerIrq", 16'h0000, {15'h0000, timerIrq});
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("timerIrq", 16'h0001, {15'h0000, timerIrq});
      host_u.rd(ST, 16'h0001);
      host_u.wr(CL, 16'h0000);
      host_u.rd(CL, 16'h0005);
      host_u.wr(ST, 16'h0001);
      @(negedge sys_clk);
      chk("timerIrq", 16'h0000, {15'h0000, timerIrq});
      host_u.rd(ST, 16'h0001);
      host_u.wr(ST, 16'h0000);
      host_u.rd(ST, 16'h0000);
      host_u.wr(SE, 16'h0006);
      repeat (20) @(posedge sys_clk);
      host_u.rd(ST, 16'h0003);
      @(negedge sys_clk);
      chk("timerIrq", 16'h0000, {15'h0000, timerIrq});
      host_u.wr(SE, 16'h000C);
      host_u.wr(ST, 16'h0000);
      host_u.rd(ST, 16'h0000);
      host_u.wr(ST, 16'h0002);
      host_u.rd(ST, 16'h0000);
      // Start and stop together from idle must not start the counter
      host_u.wr(SE, 16'h000C);
      host_u.rd(ST, 16'h0000);
      host_u.wr(PL, 16'h03E8);
      host_u.wr(CL, 16'hFFFF);
      host_u.rd(CL, 16'h03E8);
      host_u.wr(SE, 16'h0004);
      repeat (10) @(posedge sys_clk);
      host_u.wr(CL, 16'h0000);
      host_u.wr(SE, 16'h0008);
      host_u.rd(CL, 16'h03DD);
      host_u.rd(CH, 16'h0000);
      host_u.rd(ST, 16'h0000);
      repeat (3) @(posedge sys_clk);
      results();
   end
endmodule
bind itmr_top itmr_asserts #(.RESET_COUNT(RESET_COUNT)) chk_u (.sys_clk(sys_clk),
   .resetn(resetn), .busAddr(busAddr), .busWrData(busWrData), .busWrStb(busWrStb),
   .busRdStb(busRdStb), .busRdData(busRdData), .timerIrq(timerIrq));
